/* File: rtl/pbcg_pkg.sv */
// package of widths, reset values and carriers for the pll base clock generator
package pbcg_pkg;

  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int REF_DIV_W = 6;   // reference divide factor r
  localparam int PRESC_W   = 2;   // power-of-two prescale p
  localparam int MULT_W    = 12;  // modulo feedback factor n
  localparam int RANGE_W   = 8;   // linear range factor l
  localparam int EXP_W     = 2;   // power-of-two range factor e
  localparam int FREQ_W    = 32;  // width of the centre frequency in hertz

  // ----------------------------------------------------------------
  // constants and reset values
  // ----------------------------------------------------------------
  localparam logic [FREQ_W-1:0]    NOM_FREQ_HZ     = 32'h0000_9600; // 38400 hz base
  localparam logic [2:0]           TRACK_GOOD_CNT  = 3'h2; // good windows to track
  localparam logic [2:0]           LOCK_GOOD_CNT   = 3'h4; // good windows to lock
  localparam logic [REF_DIV_W-1:0] REF_DIV_RST     = 6'h01;
  localparam logic [PRESC_W-1:0]   PRESC_RST       = 2'h0;
  localparam logic [MULT_W-1:0]    MULT_RST        = 12'h001;
  localparam logic [RANGE_W-1:0]   RANGE_RST       = 8'h00;
  localparam logic [EXP_W-1:0]     EXP_RST         = 2'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic auto_bw;
    logic lock_irq_enable;
    logic filter_track_select;
    logic pll_power_on;
    logic base_source_select;
  } pbcg_ctrl_t;

  typedef struct packed {
    logic [REF_DIV_W-1:0] ref_div;
    logic [PRESC_W-1:0]   prescale;
    logic [MULT_W-1:0]    mult;
    logic [RANGE_W-1:0]   vco_range_select;
    logic [EXP_W-1:0]     range_exp;
  } pbcg_prog_t;

  typedef struct packed {
    logic lock_change_flag;
    logic locked;
    logic filter_track_select;
    logic lock_irq_enable;
    logic pll_power_on;
    logic base_source_select;
    logic base_from_vco;
  } pbcg_status_t;

endpackage

/* File: rtl/pbcg_top.sv */
// digital side of the pll base clock generator
`timescale 1ns/1ps

module pbcg_top (
  input  wire logic                  SYS_CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  OSC_ENABLE_REQUEST,
  input  wire logic                  OSC_CLOCK,
  input  wire logic                  VCO_CLOCK,
  input  wire logic                  CTRL_WRITE,
  input  wire pbcg_pkg::pbcg_ctrl_t  CTRL_DATA,
  input  wire logic                  PROG_WRITE,
  input  wire pbcg_pkg::pbcg_prog_t  PROG_DATA,
  input  wire logic                  FLAG_CLEAR,
  output logic                       OSC_RUN,
  output logic                       BUFFERED_REF_CLOCK,
  output logic                       DIVIDED_REF_CLOCK,
  output logic                       VCO_FEEDBACK_CLOCK,
  output logic                       PUMP_UP,
  output logic                       PUMP_DOWN,
  output logic                       BASE_CLOCK_OUT,
  output logic                       LOCK_IRQ,
  output pbcg_pkg::pbcg_status_t     STATUS,
  output pbcg_pkg::pbcg_prog_t       PROG,
  output logic [31:0]                CENTER_FREQ_HZ
);
  import pbcg_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] osc_sync;
  logic [2:0] vco_sync;
  logic [1:0] oen_sync;
  logic       osc_rise;
  logic       vco_rise;

  // stage 0 is read only by stage 1; edges come from stages 1 and 2
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      osc_sync <= 3'h0;
      vco_sync <= 3'h0;
      oen_sync <= 2'h0;
    end else begin
      osc_sync <= {osc_sync[1:0], OSC_CLOCK};
      vco_sync <= {vco_sync[1:0], VCO_CLOCK};
      oen_sync <= {oen_sync[0], OSC_ENABLE_REQUEST};
    end
  end
  assign osc_rise = osc_sync[1] & ~osc_sync[2];
  assign vco_rise = vco_sync[1] & ~vco_sync[2];

  // ----------------------------------------------------------------
  // control bits with their interlocks
  // ----------------------------------------------------------------
  pbcg_ctrl_t ctrl;
  pbcg_prog_t prog;
  logic       track_hw;
  logic       locked_hw;
  logic       range_zero;

  assign range_zero = (prog.vco_range_select == '0);

  // a write sees the power, select and track interlocks of the state before it; irq enable uses the written auto_bw
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl <= '0;
    end else if (CTRL_WRITE) begin
      ctrl.auto_bw <= CTRL_DATA.auto_bw;
      ctrl.lock_irq_enable <= CTRL_DATA.auto_bw & CTRL_DATA.lock_irq_enable;
      if (!ctrl.auto_bw) begin
        ctrl.filter_track_select <= CTRL_DATA.filter_track_select;
      end
      ctrl.pll_power_on <= CTRL_DATA.pll_power_on | ctrl.base_source_select;
      ctrl.base_source_select <= CTRL_DATA.base_source_select
                                 & ctrl.pll_power_on & ~range_zero;
    end else begin
      if (!ctrl.pll_power_on || range_zero) begin
        ctrl.base_source_select <= 1'b0;
      end
      if (ctrl.auto_bw) begin
        ctrl.filter_track_select <= track_hw;
      end
    end
  end

  // multiplier settings freeze while the loop is running
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      prog <= '{REF_DIV_RST, PRESC_RST, MULT_RST, RANGE_RST, EXP_RST};
    end else if (PROG_WRITE && !ctrl.pll_power_on) begin
      prog <= PROG_DATA;
    end
  end

  // ----------------------------------------------------------------
  // oscillator gate, reference buffer and reference divider
  // ----------------------------------------------------------------
  logic [REF_DIV_W-1:0] ref_cnt;
  logic                 ref_tick;

  // a zero factor behaves as one so the divider never stalls
  assign ref_tick = osc_rise & OSC_RUN &
                    ((ref_cnt + 6'h01 >= prog.ref_div) || prog.ref_div == '0);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      OSC_RUN            <= 1'b0;
      BUFFERED_REF_CLOCK <= 1'b0;
      DIVIDED_REF_CLOCK  <= 1'b0;
      ref_cnt            <= '0;
    end else begin
      OSC_RUN            <= oen_sync[1];
      BUFFERED_REF_CLOCK <= osc_sync[1] & OSC_RUN;
      DIVIDED_REF_CLOCK  <= ref_tick;
      if (ref_tick) begin
        ref_cnt <= '0;
      end else if (osc_rise && OSC_RUN) begin
        ref_cnt <= ref_cnt + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // vco prescaler and modulo feedback divider
  // ----------------------------------------------------------------
  logic [2:0]        pre_cnt;
  logic [MULT_W-1:0] fb_cnt;
  logic              pre_tick;
  logic              fb_tick;

  assign pre_tick = vco_rise & ctrl.pll_power_on &
                    (pre_cnt == 3'((4'h1 << prog.prescale) - 4'h1));
  assign fb_tick  = pre_tick & ((fb_cnt + 12'h001 >= prog.mult) || prog.mult == '0);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !ctrl.pll_power_on) begin
      pre_cnt            <= 3'h0;
      fb_cnt             <= '0;
      VCO_FEEDBACK_CLOCK <= 1'b0;
    end else begin
      VCO_FEEDBACK_CLOCK <= fb_tick;
      if (pre_tick) begin
        pre_cnt <= 3'h0;
      end else if (vco_rise) begin
        pre_cnt <= pre_cnt + 3'h1;
      end
      if (fb_tick) begin
        fb_cnt <= '0;
      end else if (pre_tick) begin
        fb_cnt <= fb_cnt + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // phase detector
  // ----------------------------------------------------------------
  // pulse width is the time between the two divided edges
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !ctrl.pll_power_on) begin
      PUMP_UP   <= 1'b0;
      PUMP_DOWN <= 1'b0;
    end else if (ref_tick && fb_tick) begin
      PUMP_UP   <= 1'b0;
      PUMP_DOWN <= 1'b0;
    end else if (ref_tick) begin
      PUMP_UP   <= ~PUMP_DOWN;
      PUMP_DOWN <= 1'b0;
    end else if (fb_tick) begin
      PUMP_DOWN <= ~PUMP_UP;
      PUMP_UP   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // lock detector: one feedback edge per reference window is good
  // ----------------------------------------------------------------
  logic [1:0] win_cnt;
  logic [2:0] good_run;
  logic       win_good;

  assign win_good  = (win_cnt == 2'h1) || (win_cnt == 2'h0 && fb_tick);
  assign track_hw  = (good_run >= TRACK_GOOD_CNT);
  assign locked_hw = (good_run >= LOCK_GOOD_CNT);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !ctrl.pll_power_on || !ctrl.auto_bw) begin
      win_cnt  <= 2'h0;
      good_run <= 3'h0;
    end else if (ref_tick) begin
      win_cnt <= 2'h0;
      if (!win_good) begin
        good_run <= 3'h0;
      end else if (good_run != LOCK_GOOD_CNT) begin
        good_run <= good_run + 3'h1;
      end
    end else if (fb_tick && win_cnt != 2'h3) begin
      win_cnt <= win_cnt + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // lock change flag and interrupt request
  // ----------------------------------------------------------------
  logic locked_q;
  logic lock_flag;

  // a lock change in the clearing cycle still sets the flag
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      locked_q  <= 1'b0;
      lock_flag <= 1'b0;
      LOCK_IRQ  <= 1'b0;
    end else begin
      locked_q <= locked_hw;
      if (ctrl.auto_bw && locked_hw != locked_q) begin
        lock_flag <= 1'b1;
      end else if (FLAG_CLEAR || !ctrl.auto_bw) begin
        lock_flag <= 1'b0;
      end
      LOCK_IRQ <= lock_flag & ctrl.lock_irq_enable & ctrl.auto_bw;
    end
  end

  // ----------------------------------------------------------------
  // base clock selector with glitch-free switchover
  // ----------------------------------------------------------------
  logic use_vco;
  logic sw_wait;
  logic src_rise;

  assign src_rise = use_vco ? vco_rise : (osc_rise & OSC_RUN);

  // a switch happens only in the cycle of a falling output edge; the new source
  // edge that follows is skipped so the low phase is at least a full period
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      BASE_CLOCK_OUT <= 1'b0;
      use_vco        <= 1'b0;
      sw_wait        <= 1'b0;
    end else if (sw_wait) begin
      if (src_rise) begin
        sw_wait <= 1'b0;
      end
    end else if (src_rise) begin
      BASE_CLOCK_OUT <= ~BASE_CLOCK_OUT;
      if (BASE_CLOCK_OUT && use_vco != ctrl.base_source_select) begin
        use_vco <= ctrl.base_source_select;
        sw_wait <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // status and centre frequency
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      STATUS         <= '0;
      PROG           <= '{REF_DIV_RST, PRESC_RST, MULT_RST, RANGE_RST, EXP_RST};
      CENTER_FREQ_HZ <= '0;
    end else begin
      STATUS.lock_change_flag    <= lock_flag & ctrl.auto_bw;
      STATUS.locked              <= locked_hw & ctrl.auto_bw;
      STATUS.filter_track_select <= ctrl.filter_track_select;
      STATUS.lock_irq_enable     <= ctrl.lock_irq_enable;
      STATUS.pll_power_on        <= ctrl.pll_power_on;
      STATUS.base_source_select  <= ctrl.base_source_select;
      STATUS.base_from_vco       <= use_vco;
      PROG                       <= prog;
      CENTER_FREQ_HZ <= 32'((32'(prog.vco_range_select) << prog.range_exp)
                            * NOM_FREQ_HZ);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_switch_edge;
    src_rise && BASE_CLOCK_OUT && !sw_wait && use_vco != ctrl.base_source_select;
  endsequence

  a_irq_needs_auto: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !ctrl.auto_bw |-> !ctrl.lock_irq_enable)
    else $error("irq enable set in manual mode");
  a_status_zero_manual: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !ctrl.auto_bw |=> !STATUS.locked && !STATUS.lock_change_flag)
    else $error("lock status visible in manual mode");
  a_select_needs_power: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (!ctrl.pll_power_on || range_zero) |=> !ctrl.base_source_select)
    else $error("source select held without power or range");
  a_prog_frozen: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ctrl.pll_power_on |=> $stable(prog))
    else $error("programming changed while powered");
  a_power_held: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ctrl.base_source_select |=> ctrl.pll_power_on)
    else $error("power dropped while vco selected");
  a_osc_gate: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !oen_sync[1] |=> !OSC_RUN ##1 !BUFFERED_REF_CLOCK)
    else $error("oscillator running without enable");
  a_ref_tick_out: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ref_tick |=> DIVIDED_REF_CLOCK)
    else $error("divided reference pulse missing");
  a_lock_flag_set: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (ctrl.auto_bw && locked_hw != locked_q) |=> lock_flag ##1 STATUS.lock_change_flag)
    else $error("lock change not flagged");
  a_track_follows: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (ctrl.auto_bw && !CTRL_WRITE) |=> ctrl.filter_track_select == $past(track_hw))
    else $error("track bit not following detector");
  a_switch_holds_low: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    s_switch_edge |=> !BASE_CLOCK_OUT && sw_wait)
    else $error("source switch did not hold the low phase");

endmodule

/* File: bench/pbcg_sim_model.sv */
// system integration partner: oscillator enable and bus clock derivation
`timescale 1ns/1ps
module pbcg_sim_model (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic osc_want,
  input  wire logic base_clock_out,
  output logic      osc_enable_request,
  output logic      bus_clock
);
  logic base_prev;
  // the oscillator may only run while this side asks for it
  always_ff @(posedge sys_clk) begin
    osc_enable_request <= sys_rst ? 1'b0 : osc_want;
  end
  // bus clock halves the base clock; edge counting keeps the duty at half
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      base_prev <= 1'b0;
      bus_clock <= 1'b0;
    end else begin
      base_prev <= base_clock_out;
      if (base_clock_out && !base_prev) begin
        bus_clock <= ~bus_clock;
      end
    end
  end
endmodule

/* File: bench/tb.sv */
// self-checking bench for the pll base clock generator
`timescale 1ns/1ps
module tb;
  import pbcg_pkg::*;
  logic         sys_clk, sys_rst, osc_clock, vco_clock, osc_want, osc_en, bus_clock;
  logic         ctrl_write, prog_write, flag_clear, run, bref, dref, vfb, up, dn, base, irq;
  logic         m_pon, m_sel, m_ie, seen;
  pbcg_ctrl_t   ctrl_data;
  pbcg_prog_t   prog_data, prog_m, prog_q;
  pbcg_status_t status;
  logic [31:0]  freq;
  int           errors, checks, seed, osc_cnt, vco_cnt, vco_half, n;

  pbcg_top u_pbcg_top (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .OSC_ENABLE_REQUEST(osc_en),
    .OSC_CLOCK(osc_clock), .VCO_CLOCK(vco_clock), .CTRL_WRITE(ctrl_write),
    .CTRL_DATA(ctrl_data), .PROG_WRITE(prog_write), .PROG_DATA(prog_data),
    .FLAG_CLEAR(flag_clear), .OSC_RUN(run), .BUFFERED_REF_CLOCK(bref),
    .DIVIDED_REF_CLOCK(dref), .VCO_FEEDBACK_CLOCK(vfb), .PUMP_UP(up), .PUMP_DOWN(dn),
    .BASE_CLOCK_OUT(base), .LOCK_IRQ(irq), .STATUS(status), .PROG(prog_q),
    .CENTER_FREQ_HZ(freq));
  pbcg_sim_model u_pbcg_sim_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .osc_want(osc_want),
    .base_clock_out(base), .osc_enable_request(osc_en), .bus_clock(bus_clock));

  // ----------------------------------------------------------------
  // clocks: osc half period 8 cycles, vco half period set by the scenario
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    osc_cnt = osc_cnt + 1;
    vco_cnt = vco_cnt + 1;
    if (osc_cnt >= 8) begin
      osc_clock <= ~osc_clock;
      osc_cnt = 0;
    end
    if (vco_cnt >= vco_half) begin
      vco_clock <= ~vco_clock;
      vco_cnt = 0;
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // the power and select interlock model uses the state from before the write, as the device does
  task automatic ctrl(input logic ab, ie, tr, pon, sel);
    logic old_sel;
    ctrl_write = 1'b1;
    ctrl_data = {ab, ie, tr, pon, sel};
    @(negedge sys_clk);
    ctrl_write = 1'b0;
    old_sel = m_sel;
    // select needs the old power bit; power is held by the old select
    m_sel = sel & m_pon & (prog_m.vco_range_select != 8'h00) & (pon | old_sel);
    m_pon = pon | old_sel;
    m_ie = ab & ie;
    cycles(2);
    check({status.lock_irq_enable, status.pll_power_on, status.base_source_select},
          {m_ie, m_pon, m_sel}, "control");
    if (!ab) check({status.lock_change_flag, status.locked}, 0, "manual lock");
  endtask
  task automatic prog(input logic [5:0] rd, input logic [1:0] ps, input logic [11:0] mu,
                      input logic [7:0] l, input logic [1:0] e);
    prog_write = 1'b1;
    prog_data = {rd, ps, mu, l, e};
    @(negedge sys_clk);
    prog_write = 1'b0;
    if (!m_pon) prog_m = {rd, ps, mu, l, e};
    cycles(2);
    check(prog_q, prog_m, "prog");
    check(freq, prog_m.vco_range_select * (32'h1 << prog_m.range_exp) * NOM_FREQ_HZ, "freq");
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? dref : k == 1 ? vfb : k == 2 ? base : k == 3 ? bus_clock : bref;
  endfunction
  // cycles between two rising edges of the picked signal, bounded
  task automatic period(input int k, input int exp);
    int c, e;
    logic p;
    c = 0;
    e = 0;
    n = 0;
    p = pick(k);
    while (e < 2 && n < 800) begin
      @(negedge sys_clk);
      if (e == 1) c++;
      if (pick(k) && !p) e++;
      p = pick(k);
      n++;
    end
    if (e < 2) begin
      errors++;
      $display("mismatch at %0t: no edges on signal %0d", $time, k);
      finish_test;
    end
    check(c, exp, "period");
  endtask
  task automatic wait_bit(input int idx, input logic val);
    n = 0;
    while (status[idx] !== val && n < 3000) begin
      @(negedge sys_clk);
      seen = seen | dn;
      n++;
    end
    if (n >= 3000) begin
      errors++;
      $display("mismatch at %0t: status bit %0d stuck", $time, idx);
      finish_test;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {ctrl_write, prog_write, flag_clear, osc_clock, vco_clock, m_pon, m_sel, m_ie} = '0;
    {ctrl_data, prog_data, seen, errors, checks, osc_cnt, vco_cnt} = '0;
    seed = 28284;
    vco_half = 4;
    osc_want = 1'b1;
    prog_m = {REF_DIV_RST, PRESC_RST, MULT_RST, RANGE_RST, EXP_RST};
    sys_rst = 1'b1;
    cycles(16);
    sys_rst = 1'b0;
    check(status, 0, "reset status");
    check(prog_q, prog_m, "reset prog");
    osc_want = 1'b0;
    cycles(8);
    n = 0;
    repeat (40) begin
      cycles(1);
      n = n + bref + run;
    end
    check(n, 0, "osc gated");
    osc_want = 1'b1;
    period(4, 16);
    for (int e = 0; e < 4; e++) prog(6'h03, 2'h1, 12'h003, $random(seed) | 1, e[1:0]);
    period(0, 3 * 16);
    ctrl(0, 0, 0, 0, 1);
    ctrl(0, 1, 0, 1, 0);
    period(1, 3 * 2 * 2 * vco_half);
    prog(6'h01, 2'h0, 12'h002, 8'h05, 2'h0);
    period(2, 2 * 16);
    period(3, 4 * 16);
    ctrl(0, 0, 0, 1, 1);
    wait_bit(0, 1'b1);
    period(2, 2 * 2 * vco_half);
    ctrl(0, 0, 0, 0, 1);
    ctrl(0, 0, 0, 0, 0);
    ctrl(0, 0, 0, 0, 0);
    prog(6'h01, 2'h0, 12'h002, 8'h10, 2'h1);
    ctrl(1, 1, 0, 1, 0);
    wait_bit(5, 1'b1);
    cycles(2);
    check({status.lock_change_flag, status.filter_track_select, irq}, 3'h7, "lock");
    ctrl(1, 1, 0, 1, 0);
    check(status.filter_track_select, 1'b1, "track held");
    flag_clear = 1'b1;
    cycles(1);
    flag_clear = 1'b0;
    cycles(3);
    check({status.lock_change_flag, irq}, 0, "flag clear");
    vco_half = 3;
    seen = 1'b0;
    wait_bit(5, 1'b0);
    cycles(2);
    check({status.lock_change_flag, seen}, 2'h3, "unlock");
    ctrl(0, 1, 0, 1, 0);
    finish_test;
  end
endmodule
